// ---- design/tg_tone_top.sv ----
/*
 * tg_tone_top: dual sine tone and beep generator with Wishbone register port.
 * Assumes a 100 MHz clock, a classic Wishbone master and a mixer taking
 * tone_sample whenever tone_valid pulses.
 */
`timescale 1ns/1ps
// Function
// - two generators, each with 16-bit word
// - frequencies from about 1 Hz to 12 kHz
// - word = 65536*f/12000 for 12k rate family
// - word = 65536*f/11025 for 11.025k family
// - each word split into high and low bytes
// - selector picks generator one, two or sum
// - keypad enable drives both generators from code
// - standard row/column tone table per keypad code
// - burst of beeps or continuous beep
// - on and off times 10 ms to 2 s
// - run bit set starts, clear requests halt
// - finish cycle, continuous stops at zero crossing
// - run bit self-clears after last beep
// - selector three gives s-shaped ramp
module tg_tone_top #(
   parameter int CLK_HZ      = tg_pkg::TG_CLK_HZ,
   parameter int UNIT_CYCLES = tg_pkg::TG_UNIT_CYCLES
) (
   input  wire logic        clk,
   input  wire logic        rst_b,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   output logic      [15:0] tone_sample,
   output logic             tone_valid,
   output logic             beep_active
);
   import tg_pkg::*;

   // register state
   logic        run_reg;
   logic        dtmf_en_reg;
   logic [1:0]  gen_sel_reg;
   logic [2:0]  beep_cycles_reg;
   logic [3:0]  keypad_reg;
   logic [3:0]  rate_reg;
   logic [7:0]  tone1_frequency_high_byte;
   logic [7:0]  tone1_frequency_low_byte;
   logic [7:0]  tone2_frequency_high_byte;
   logic [7:0]  tone2_frequency_low_byte;
   logic [7:0]  beep_on_reg;
   logic [7:0]  beep_off_reg;

   // sequencer state
   tg_state_e   state_reg;
   logic [31:0] unit_cnt_reg;
   logic [7:0]  per_cnt_reg;
   logic [5:0]  beeps_reg;
   logic [23:0] rate_cnt_reg;
   logic        sign_prev_reg;

   // combinational helpers
   logic        bus_req;
   logic        wr_en;
   logic        wr_ctrl;
   logic [31:0] rd_data;
   logic [31:0] ctrl_word;
   logic [31:0] status_word;
   logic        sample_tick;
   logic        unit_tick;
   logic        continuous;
   logic [5:0]  beep_target;
   logic [5:0]  beeps_next;
   logic        last_unit;
   logic        hw_clear;
   logic        zero_cross;
   logic [3:0]  rate_idx;
   logic [23:0] rate_div;
   logic        family;
   logic [3:0]  key_pos;
   logic [15:0] word1;
   logic [15:0] word2;
   logic [7:0]  on_len;
   logic [7:0]  off_len;
   logic signed [15:0] mix;

   // constant tables built at elaboration
   logic [23:0] div_tbl [TG_NUM_RATES];
   logic [15:0] row_tbl [2][4];
   logic [15:0] col_tbl [2][4];

   tg_tone_if tif [2] ();

   // divisors from the clock rate: shortened together with CLK_HZ in simulation
   genvar g;
   generate
      for (g = 0; g < TG_NUM_RATES; g++) begin : g_div
         assign div_tbl[g] = 24'(CLK_HZ / TG_RATE_HZ[g]);
      end
      for (g = 0; g < 8; g++) begin : g_key
         // keypad words for both families, same formula software uses
         assign row_tbl[g / 4][g % 4] = 16'((65536 * TG_ROW_HZ[g % 4]) / TG_BASE_HZ[g / 4]);
         assign col_tbl[g / 4][g % 4] = 16'((65536 * TG_COL_HZ[g % 4]) / TG_BASE_HZ[g / 4]);
      end
   endgenerate

   // unknown rate codes fall back to 48 kHz rather than stalling the tick
   assign rate_idx = (rate_reg < 4'(TG_NUM_RATES)) ? rate_reg : TG_RATE_RST;
   assign rate_div = div_tbl[rate_idx];
   assign family   = TG_RATE_FAM[rate_idx];

   // frequency words: programmed bytes or the keypad pair
   assign key_pos = TG_KEY_POS[keypad_reg];
   always_comb begin
      if (dtmf_en_reg) begin
         word1 = col_tbl[family][key_pos[1:0]];
         word2 = row_tbl[family][key_pos[3:2]];
      end else begin
         word1 = {tone1_frequency_high_byte, tone1_frequency_low_byte};
         word2 = {tone2_frequency_high_byte, tone2_frequency_low_byte};
      end
   end

   // drive both generators; the phase clear in idle makes the first beep after a start begin at zero
   generate
      for (g = 0; g < 2; g++) begin : g_gen
         assign tif[g].freq_word = (g == 0) ? word1 : word2;
         assign tif[g].rate_mul  = TG_RATE_MUL[rate_idx];
         assign tif[g].tick      = sample_tick;
         assign tif[g].clear     = (state_reg == TG_ST_IDLE);
         tg_sine_gen u_gen (
            .clk   (clk),
            .rst_b (rst_b),
            .tone  (tif[g])
         );
      end
   endgenerate

   // output selector
   always_comb begin
      case (gen_sel_reg)
         TG_SEL_GEN1: mix = tif[0].sine;
         TG_SEL_GEN2: mix = tif[1].sine;
         TG_SEL_SUM:  mix = (tif[0].sine >>> 1) + (tif[1].sine >>> 1);
         default:     mix = tif[0].sramp;
      endcase
   end

   // sample-rate divider: one enable pulse per output sample
   assign sample_tick = (rate_cnt_reg >= rate_div - 24'h000001);
   always_ff @(posedge clk) begin
      if (!rst_b || sample_tick) begin
         rate_cnt_reg <= 24'h000000;
      end else begin
         rate_cnt_reg <= rate_cnt_reg + 24'h000001;
      end
   end

   // beep count decode and period clamps
   assign continuous  = (beep_cycles_reg > 3'h5);
   always_comb begin
      case (beep_cycles_reg)
         3'h0:    beep_target = 6'h01;
         3'h1:    beep_target = 6'h02;
         3'h2:    beep_target = 6'h03;
         3'h3:    beep_target = 6'h04;
         3'h4:    beep_target = 6'h08;
         default: beep_target = 6'h10;
      endcase
   end
   assign on_len  = (beep_on_reg < TG_PER_MIN) ? TG_PER_MIN :
                    (beep_on_reg > TG_PER_MAX) ? TG_PER_MAX : beep_on_reg;
   assign off_len = (beep_off_reg < TG_PER_MIN) ? TG_PER_MIN :
                    (beep_off_reg > TG_PER_MAX) ? TG_PER_MAX : beep_off_reg;

   assign unit_tick  = (unit_cnt_reg == 32'(UNIT_CYCLES - 1));
   assign last_unit  = unit_tick && (per_cnt_reg == 8'h01);
   assign beeps_next = beeps_reg + 6'h01;
   assign zero_cross = sample_tick && (mix[15] != sign_prev_reg);
   // self-clear only at the end of the final off period of a burst
   assign hw_clear   = (state_reg == TG_ST_OFF) && last_unit && (beeps_next == beep_target);

   // remember sign of previous sample for zero-cross detection
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         sign_prev_reg <= 1'b0;
      end else if (sample_tick) begin
         sign_prev_reg <= mix[15];
      end
   end

   // beep sequencer
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         state_reg    <= TG_ST_IDLE;
         unit_cnt_reg <= 32'h00000000;
         per_cnt_reg  <= 8'h00;
         beeps_reg    <= 6'h00;
      end else begin
         unit_cnt_reg <= unit_tick ? 32'h00000000 : unit_cnt_reg + 32'h00000001;
         case (state_reg)
            TG_ST_IDLE: begin
               unit_cnt_reg <= 32'h00000000;
               beeps_reg    <= 6'h00;
               per_cnt_reg  <= on_len;
               if (run_reg) begin
                  state_reg <= TG_ST_ON;
               end
            end
            TG_ST_ON: begin
               if (continuous) begin
                  // uninterrupted tone until a halt meets a zero crossing
                  if (!run_reg && zero_cross) begin
                     state_reg <= TG_ST_IDLE;
                  end
               end else if (last_unit) begin
                  state_reg   <= TG_ST_OFF;
                  per_cnt_reg <= off_len;
               end else if (unit_tick) begin
                  per_cnt_reg <= per_cnt_reg - 8'h01;
               end
            end
            TG_ST_OFF: begin
               if (last_unit) begin
                  beeps_reg <= beeps_next;
                  // a halt request only takes effect once the cycle is done
                  if (!run_reg || beeps_next == beep_target) begin
                     state_reg <= TG_ST_IDLE;
                  end else begin
                     state_reg   <= TG_ST_ON;
                     per_cnt_reg <= on_len;
                  end
               end else if (unit_tick) begin
                  per_cnt_reg <= per_cnt_reg - 8'h01;
               end
            end
            default: begin
               state_reg <= TG_ST_IDLE;
            end
         endcase
      end
   end

   // stream to the mixer; silent outside the on period
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         tone_sample <= 16'h0000;
         tone_valid  <= 1'b0;
         beep_active <= 1'b0;
      end else begin
         tone_valid  <= sample_tick;
         beep_active <= (state_reg != TG_ST_IDLE);
         if (sample_tick) begin
            tone_sample <= (state_reg == TG_ST_ON) ? mix : 16'h0000;
         end
      end
   end

   // wishbone decode: ack one cycle after the strobe, never two in a row
   assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign wr_en   = bus_req && wb_we_i;
   assign wr_ctrl = wr_en && (wb_adr_i == TG_CTRL_OFS) && wb_sel_i[0];

   // run bit: a software write wins over the self-clear in the same cycle
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         run_reg <= 1'b0;
      end else if (wr_ctrl) begin
         run_reg <= wb_dat_i[TG_RUN_BIT];
      end else if (hw_clear) begin
         run_reg <= 1'b0;
      end
   end

   // writable configuration, byte lane by byte lane
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         dtmf_en_reg               <= 1'b0;
         gen_sel_reg               <= TG_SEL_GEN1;
         beep_cycles_reg           <= 3'h0;
         keypad_reg                <= 4'h0;
         rate_reg                  <= TG_RATE_RST;
         tone1_frequency_high_byte <= TG_FREQ_RST;
         tone1_frequency_low_byte  <= TG_FREQ_RST;
         tone2_frequency_high_byte <= TG_FREQ_RST;
         tone2_frequency_low_byte  <= TG_FREQ_RST;
         beep_on_reg               <= TG_PER_RST;
         beep_off_reg              <= TG_PER_RST;
      end else if (wr_en) begin
         if (wb_adr_i == TG_CTRL_OFS) begin
            if (wb_sel_i[0]) begin
               dtmf_en_reg     <= wb_dat_i[TG_DTMF_BIT];
               gen_sel_reg     <= wb_dat_i[TG_SEL_LSB +: 2];
               beep_cycles_reg <= wb_dat_i[TG_COUNT_LSB +: 3];
            end
            if (wb_sel_i[1]) begin
               keypad_reg <= wb_dat_i[TG_KEY_LSB +: 4];
            end
            if (wb_sel_i[2]) begin
               rate_reg <= wb_dat_i[TG_RATE_LSB +: 4];
            end
         end else if (wb_adr_i == TG_F1_HIGH_OFS && wb_sel_i[0]) begin
            tone1_frequency_high_byte <= wb_dat_i[7:0];
         end else if (wb_adr_i == TG_F1_LOW_OFS && wb_sel_i[0]) begin
            tone1_frequency_low_byte <= wb_dat_i[7:0];
         end else if (wb_adr_i == TG_F2_HIGH_OFS && wb_sel_i[0]) begin
            tone2_frequency_high_byte <= wb_dat_i[7:0];
         end else if (wb_adr_i == TG_F2_LOW_OFS && wb_sel_i[0]) begin
            tone2_frequency_low_byte <= wb_dat_i[7:0];
         end else if (wb_adr_i == TG_BEEP_TIME_OFS) begin
            if (wb_sel_i[0]) begin
               beep_on_reg <= wb_dat_i[7:0];
            end
            if (wb_sel_i[1]) begin
               beep_off_reg <= wb_dat_i[15:8];
            end
         end
      end
   end

   // read mux; unmapped offsets read zero and writes there are dropped
   assign ctrl_word   = {12'h000, rate_reg, 4'h0, keypad_reg, 1'b0, beep_cycles_reg,
                         gen_sel_reg, dtmf_en_reg, run_reg};
   assign status_word = {24'h000000, beeps_reg, (state_reg == TG_ST_ON), (state_reg != TG_ST_IDLE)};
   always_comb begin
      if (wb_adr_i == TG_CTRL_OFS) begin
         rd_data = ctrl_word;
      end else if (wb_adr_i == TG_F1_HIGH_OFS) begin
         rd_data = {24'h000000, tone1_frequency_high_byte};
      end else if (wb_adr_i == TG_F1_LOW_OFS) begin
         rd_data = {24'h000000, tone1_frequency_low_byte};
      end else if (wb_adr_i == TG_F2_HIGH_OFS) begin
         rd_data = {24'h000000, tone2_frequency_high_byte};
      end else if (wb_adr_i == TG_F2_LOW_OFS) begin
         rd_data = {24'h000000, tone2_frequency_low_byte};
      end else if (wb_adr_i == TG_BEEP_TIME_OFS) begin
         rd_data = {16'h0000, beep_off_reg, beep_on_reg};
      end else if (wb_adr_i == TG_STATUS_OFS) begin
         rd_data = status_word;
      end else begin
         rd_data = 32'h00000000;
      end
   end

   // registered answer
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h00000000;
      end else begin
         wb_ack_o <= bus_req;
         wb_dat_o <= bus_req ? rd_data : 32'h00000000;
      end
   end

endmodule // tg_tone_top

// ---- design/tg_pkg.sv ----
/*
 * tg_pkg: constants, tables and helpers for the dual sine tone / beep generator.
 * Assumes a 100 MHz system clock and a 32-bit classic Wishbone register port.
 */
package tg_pkg;

   // register byte offsets (one aligned word each)
   localparam logic [7:0] TG_CTRL_OFS      = 8'h00;
   localparam logic [7:0] TG_F1_HIGH_OFS   = 8'h04;
   localparam logic [7:0] TG_F1_LOW_OFS    = 8'h08;
   localparam logic [7:0] TG_F2_HIGH_OFS   = 8'h0c;
   localparam logic [7:0] TG_F2_LOW_OFS    = 8'h10;
   localparam logic [7:0] TG_BEEP_TIME_OFS = 8'h14;
   localparam logic [7:0] TG_STATUS_OFS    = 8'h18;

   // control word field positions
   localparam int TG_RUN_BIT   = 0;
   localparam int TG_DTMF_BIT  = 1;
   localparam int TG_SEL_LSB   = 2;
   localparam int TG_COUNT_LSB = 4;
   localparam int TG_KEY_LSB   = 8;
   localparam int TG_RATE_LSB  = 16;

   // reset values
   localparam logic [7:0] TG_FREQ_RST   = 8'h00;
   localparam logic [7:0] TG_PER_RST    = 8'h0a;   // 100 ms
   localparam logic [3:0] TG_RATE_RST   = 4'h8;    // 48 kHz

   // beep periods are counted in 10 ms units, 10 ms .. 2 s
   localparam int TG_UNIT_MS      = 10;
   localparam logic [7:0] TG_PER_MIN = 8'h01;
   localparam logic [7:0] TG_PER_MAX = 8'hc8;      // 200 units = 2 s
   localparam int TG_CLK_HZ       = 100_000_000;
   localparam int TG_UNIT_CYCLES  = TG_CLK_HZ / 1000 * TG_UNIT_MS;

   // output selector codes
   localparam logic [1:0] TG_SEL_GEN1  = 2'h0;
   localparam logic [1:0] TG_SEL_GEN2  = 2'h1;
   localparam logic [1:0] TG_SEL_SUM   = 2'h2;
   localparam logic [1:0] TG_SEL_SRAMP = 2'h3;

   // output sample rates, frequency word base and per-sample phase scale (1.8)
   localparam int TG_NUM_RATES = 11;
   localparam int TG_RATE_HZ [TG_NUM_RATES] = '{8000, 11025, 12000, 16000, 22050, 24000,
                                                32000, 44100, 48000, 88200, 96000};
   localparam logic [8:0] TG_RATE_MUL [TG_NUM_RATES] = '{9'h180, 9'h100, 9'h100, 9'h0c0, 9'h080,
                                                         9'h080, 9'h060, 9'h040, 9'h040, 9'h020,
                                                         9'h020};
   localparam logic TG_RATE_FAM [TG_NUM_RATES] = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0,
                                                   1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
   localparam int TG_BASE_HZ [2] = '{12000, 11025};

   // keypad tones: low row tones on generator 2, high column tones on generator 1
   localparam int TG_ROW_HZ [4] = '{697, 770, 852, 941};
   localparam int TG_COL_HZ [4] = '{1209, 1336, 1477, 1633};
   // keypad code -> {row, column}
   localparam logic [3:0] TG_KEY_POS [16] = '{4'hd, 4'h0, 4'h1, 4'h2, 4'h4, 4'h5, 4'h6, 4'h8,
                                              4'h9, 4'ha, 4'h3, 4'h7, 4'hb, 4'hf, 4'hc, 4'he};

   // quarter-wave sine, sampled at bin centres so the mirror is seamless
   localparam logic [15:0] TG_QSINE [16] = '{16'h0648, 16'h12c8, 16'h1f1a, 16'h2b1f,
                                             16'h36ba, 16'h41ce, 16'h4c3f, 16'h55f5,
                                             16'h5ed7, 16'h66cf, 16'h6dc9, 16'h73b5,
                                             16'h7884, 16'h7c29, 16'h7e9c, 16'h7fd8};

   // phase (16-bit, full turn) to signed sample
   function automatic logic signed [15:0] tg_sine(input logic [15:0] ph);
      logic [3:0]  idx;
      logic [15:0] mag;
      idx = ph[14] ? ~ph[13:10] : ph[13:10];
      mag = TG_QSINE[idx];
      return ph[15] ? -$signed(mag) : $signed(mag);
   endfunction

   typedef enum logic [2:0] {
      TG_ST_IDLE = 3'b001,
      TG_ST_ON   = 3'b010,
      TG_ST_OFF  = 3'b100
   } tg_state_e;

endpackage

// ---- design/tg_tone_if.sv ----
/*
 * tg_tone_if: link between the sequencer and one sine generator.
 * Assumes both ends run on the single system clock.
 */
`timescale 1ns/1ps
interface tg_tone_if;
   import tg_pkg::*;
   logic [15:0]        freq_word;  // phase step at the family base rate
   logic [8:0]         rate_mul;   // scale from base rate to sample rate
   logic               tick;       // one pulse per output sample
   logic               clear;      // hold phase at zero
   logic signed [15:0] sine;       // registered sine sample
   logic signed [15:0] sramp;      // registered s-ramp sample

   modport ctl (output freq_word, rate_mul, tick, clear, input sine, sramp);
   modport gen (input freq_word, rate_mul, tick, clear, output sine, sramp);
endinterface

// ---- design/tg_sine_gen.sv ----
/*
 * tg_sine_gen: one phase-accumulator sine generator with s-ramp tap.
 * Assumes tick pulses once per output sample and a word scaled to 12000 or 11025 Hz.
 */
`timescale 1ns/1ps
module tg_sine_gen (
   input  wire logic clk,
   input  wire logic rst_b,
   tg_tone_if.gen    tone
);
   import tg_pkg::*;

   logic [23:0] phase_reg;   // 16-bit phase integer, 8 fraction bits
   logic [24:0] step;
   logic [15:0] ramp_ph;

   // step scaled by base/sample ratio keeps the word meaning fixed per family
   assign step    = tone.freq_word * tone.rate_mul;
   assign ramp_ph = {1'b0, phase_reg[23:9]} - 16'h4000;

   // accumulator advances once per sample
   always_ff @(posedge clk) begin
      if (!rst_b || tone.clear) begin
         phase_reg <= 24'h000000;
      end else if (tone.tick) begin
         phase_reg <= phase_reg + step[23:0];
      end
   end

   // sine and s-ramp lookups, registered on the sample tick
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         tone.sine  <= 16'sh0000;
         tone.sramp <= 16'sh0000;
      end else if (tone.tick) begin
         tone.sine  <= tg_sine(phase_reg[23:8]);
         tone.sramp <= tg_sine(ramp_ph);
      end
   end

endmodule // tg_sine_gen

// ---- sim/tg_tone_top_monitor.sv ----
/* tg_tone_top_monitor: port-level checks of the tone generator.
   Assumes it is bound into tg_tone_top. */
`timescale 1ns/1ps
module tg_tone_top_monitor
   import tg_pkg::*;
#(
   parameter int UNIT_CYCLES = 20
) (
   input wire logic        clk,
   input wire logic        rst_b,
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic        wb_we_i,
   input wire logic [7:0]  wb_adr_i,
   input wire logic [3:0]  wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic        wb_ack_o,
   input wire logic [15:0] tone_sample,
   input wire logic        tone_valid,
   input wire logic        beep_active
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);
   logic req;
   int   act_cnt_reg;
   // request awaiting answer
   assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   // busy stretch length
   always_ff @(posedge clk) begin
      if (!rst_b || !beep_active) begin
         act_cnt_reg <= 0;
      end else begin
         act_cnt_reg <= act_cnt_reg + 1;
      end
   end
   property p_ack_next; req |=> wb_ack_o; endproperty
   a_ack_next: assert property (p_ack_next) else $error("request not answered");
   property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
   a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
   property p_dat_quiet; !wb_ack_o |-> wb_dat_o == 32'h0; endproperty
   a_dat_quiet: assert property (p_dat_quiet) else $error("read data outside ack");
   property p_start; req && wb_we_i && wb_adr_i == TG_CTRL_OFS && wb_sel_i[0] && wb_dat_i[TG_RUN_BIT]
      && !beep_active |-> ##[1:3] beep_active; endproperty
   a_start: assert property (p_start) else $error("run bit did not start a beep");
   property p_idle_silent; tone_valid && !beep_active && !$past(beep_active) && !$past(beep_active, 2)
      |-> tone_sample == 16'h0; endproperty
   a_idle_silent: assert property (p_idle_silent) else $error("sample while stopped");
   property p_hold; !tone_valid && $past(rst_b) |-> $stable(tone_sample); endproperty
   a_hold: assert property (p_hold) else $error("sample changed without valid");
   property p_valid_pulse; tone_valid |=> !tone_valid; endproperty
   a_valid_pulse: assert property (p_valid_pulse) else $error("valid longer than one cycle");
   property p_on_min; $fell(beep_active) |-> act_cnt_reg >= UNIT_CYCLES; endproperty
   a_on_min: assert property (p_on_min) else $error("beep shorter than one unit");
endmodule  // tg_tone_top_monitor

bind tg_tone_top tg_tone_top_monitor #(.UNIT_CYCLES(UNIT_CYCLES)) i_mon (.clk(clk), .rst_b(rst_b),
   .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
   .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .tone_sample(tone_sample),
   .tone_valid(tone_valid), .beep_active(beep_active));

// ---- sim/tg_mixer_model.sv ----
/* tg_mixer_model: mixer input taking one tone sample per valid pulse while beep_active is high.
   Assumes samples registered on clk. */
`timescale 1ns/1ps
module tg_mixer_model (
   input  wire logic        clk,
   input  wire logic        rst_b,
   input  wire logic        clr,
   input  wire logic        tone_valid,
   input  wire logic [15:0] tone_sample,
   input  wire logic        beep_active,
   output int               n_smp,
   output int               n_rise,
   output int               n_drop
);
   logic signed [15:0] prev_reg;
   // no back-pressure: every sample offered while beep_active is high is taken
   always_ff @(posedge clk) begin
      if (!rst_b || clr) begin
         prev_reg <= 16'sh7fff;  // positive start, no false rise
         n_smp <= 0;
         n_rise <= 0;
         n_drop <= 0;
      end else if (tone_valid && beep_active) begin
         prev_reg <= $signed(tone_sample);
         n_smp <= n_smp + 1;
         n_rise <= n_rise + int'(prev_reg < 0 && $signed(tone_sample) >= 0);
         n_drop <= n_drop + int'($signed(tone_sample) < prev_reg);
      end
   end
endmodule  // tg_mixer_model

// ---- sim/test_dual_sine_tone_beep_generator.sv ----
/* test_dual_sine_tone_beep_generator: register, beep and tone checks.
   Assumes shortened unit and clock parameters. */
`timescale 1ns/1ps
module test_dual_sine_tone_beep_generator;
   import tg_pkg::*;
   localparam int UNIT = 20;  // 10 ms unit cut to 20 clocks
   localparam int CLKHZ = 192_000;  // 4 clocks per sample at 48 kHz
   localparam logic [7:0] OFS [5] = '{TG_CTRL_OFS, TG_F1_HIGH_OFS, TG_BEEP_TIME_OFS, TG_STATUS_OFS, 8'h1c};
   localparam logic [31:0] RV [5] = '{32'h0008_0000, 32'h0, 32'h0000_0a0a, 32'h0, 32'h0};
   localparam int BN [6] = '{1, 2, 3, 4, 8, 16};
   logic        clk = 1'b0, rst_b = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0, clr = 1'b0;
   logic [7:0]  adr = 8'h0;
   logic [3:0]  sel = 4'hf;
   logic [31:0] wdat = 32'h0;
   logic [31:0] rdat, q;
   logic [15:0] smp;
   logic        ack, vld, act;
   int          n_smp, n_rise, n_drop, len, k, fails = 0, samples_checked = 0;

   always #5 clk = ~clk;
   tg_tone_top #(.CLK_HZ(CLKHZ), .UNIT_CYCLES(UNIT)) i_dut (.clk(clk), .rst_b(rst_b), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
      .wb_ack_o(ack), .tone_sample(smp), .tone_valid(vld), .beep_active(act));
   tg_mixer_model i_mix (.clk(clk), .rst_b(rst_b), .clr(clr), .tone_valid(vld), .tone_sample(smp),
      .beep_active(act), .n_smp(n_smp), .n_rise(n_rise), .n_drop(n_drop));

   task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         fails++;
         $display("MISMATCH t=%0t word %h exp %h", $time, got, exp);
      end
   endtask
   task automatic chk_rng(input int got, input int lo, input int hi);
      samples_checked++;
      if (got < lo || got > hi) begin
         fails++;
         $display("MISMATCH t=%0t count %0d not in %0d..%0d", $time, got, lo, hi);
      end
   endtask
   // one classic cycle from just after an edge, one idle cycle after
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
      int n = 0;
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      sel <= s;
      wdat <= d;
      do begin
         @(posedge clk);
         n++;
      end while (ack !== 1'b1 && n < 20);
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge clk);
      chk_rng(n, 2, 2);
   endtask
   task automatic wait_act(input logic lvl, input int lim, output int c);
      c = 0;
      while (act !== lvl && c < lim) begin
         @(posedge clk);
         c++;
      end
   endtask
   function automatic logic [31:0] cfgw(input int r, input int key, input int s, input int dt);
      return (32'(r) << TG_RATE_LSB) | (32'(key) << TG_KEY_LSB) | (32'(s) << TG_SEL_LSB) | (32'(dt) << TG_DTMF_BIT);
   endfunction
   // continuous tone: count rising crossings, then stop
   task automatic tone(input logic [31:0] cfg, input int n, input int f, input int rate);
      int e;
      e = (n * f + rate / 2) / rate;
      clr <= 1'b1;
      @(posedge clk);
      clr <= 1'b0;
      xfer(1'b1, TG_CTRL_OFS, cfg | 32'h61, 4'hf);
      k = 0;
      while (n_smp < n && k < n * 30) begin
         @(posedge clk);
         k++;
      end
      chk_rng(n_rise, e - 1, e + 1);
      xfer(1'b1, TG_CTRL_OFS, cfg | 32'h60, 4'hf);
      wait_act(1'b0, 400, k);
      chk_rng(k, 0, 399);
   endtask
   task automatic tally_and_finish();
      $display("checked %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // watchdog, well above the expected 60k cycles
   initial begin
      repeat (90_000) @(posedge clk);
      fails++;
      $display("MISMATCH t=%0t watchdog expired", $time);
      tally_and_finish();
   end
   // main sequence
   initial begin
      repeat (20) @(posedge clk);
      rst_b <= 1'b1;
      @(posedge clk);
      for (int i = 0; i < 5; i++) begin
         xfer(1'b0, OFS[i], 32'h0, 4'hf);
         chk_word(q, RV[i]);
      end
      xfer(1'b1, TG_F1_HIGH_OFS, 32'hffff_ff20, 4'hf);  // word 0x2000: 1500 Hz, under Nyquist
      xfer(1'b0, TG_F1_HIGH_OFS, 32'h0, 4'hf);
      chk_word(q, 32'h20);
      xfer(1'b1, TG_F2_HIGH_OFS, 32'h10, 4'hf);  // word 0x1000: 750 Hz
      xfer(1'b1, TG_F2_LOW_OFS, 32'h55, 4'he);  // low lane masked off
      xfer(1'b0, TG_F2_LOW_OFS, 32'h0, 4'hf);
      chk_word(q, 32'h0);
      $display("test registers done");
      xfer(1'b1, TG_BEEP_TIME_OFS, 32'h0201, 4'hf);  // on 1 unit, off 2 units
      for (int c = 0; c < 6; c++) begin
         xfer(1'b1, TG_CTRL_OFS, cfgw(8, 0, 0, 0) | (32'(c) << TG_COUNT_LSB) | 32'h1, 4'hf);
         wait_act(1'b1, 10, k);
         wait_act(1'b0, 2000, len);
         chk_rng(len, BN[c] * 3 * UNIT - 2, BN[c] * 3 * UNIT + 2);
         xfer(1'b0, TG_CTRL_OFS, 32'h0, 4'hf);
         chk_word(q, cfgw(8, 0, 0, 0) | (32'(c) << TG_COUNT_LSB));
      end
      $display("test beep counts done");
      // halt mid burst: second beep runs to its end
      xfer(1'b1, TG_CTRL_OFS, cfgw(8, 0, 0, 0) | 32'h51, 4'hf);
      wait_act(1'b1, 10, k);
      repeat (70) @(posedge clk);
      xfer(1'b1, TG_CTRL_OFS, cfgw(8, 0, 0, 0) | 32'h50, 4'hf);
      wait_act(1'b0, 500, len);
      chk_rng(73 + len, 2 * 3 * UNIT - 3, 2 * 3 * UNIT + 3);
      $display("test halt done");
      tone(cfgw(8, 0, 0, 0), 320, 1500, 48000);
      chk_rng(n_drop, 150, 172);
      tone(cfgw(8, 0, 1, 0), 320, 750, 48000);
      tone(cfgw(8, 0, 3, 0), 320, 1500, 48000);
      chk_rng(n_drop, 0, 13);
      tone(cfgw(1, 0, 0, 0), 80, 1378, 11025);
      $display("test tones done");
      for (int i = 0; i < 4; i++) begin
         tone(cfgw(0, 4 * i + 1, 1, 1), 250, TG_ROW_HZ[i], 8000);
         tone(cfgw(0, 4 * i + 1, 0, 1), 250, TG_COL_HZ[i], 8000);
      end
      $display("test keypad done");
      tally_and_finish();
   end
endmodule  // test_dual_sine_tone_beep_generator
